// File: logic/encoder_index_vector.sv
// Purpose: Quadrature counter with index handling, position compare and vector commutation.
// Assumes: Encoder pins are asynchronous; bus and position inputs share core_clk_i.
// Notes: ce_i low freezes every register, including read data.
// Function
// R1: Qualify index by configured A and B levels.
// R2: Index active level comes from polarity bit.
// R3: Skip bit bypasses A/B qualification.
// R4: Continuous mode acts on every index event.
// R5: Single shot acts on next event only.
// R6: Rising mode triggers when index becomes active.
// R7: Falling mode triggers when index becomes inactive.
// R8: Latch count on event; clear if enabled.
// R9: Compare source is ramp or encoder.
// R10: Fraction units 1/65536 or 1/10000.
// R11: Signed 6.6 vector constant accumulates per count.
// R12: Zero vector constant disables; reset value zero.
// R13: Software sets constant from steps and resolution.
// R14: Software matches constant sign to direction.
// R15: Vector angle readable, writable, 1/256 period.
// R16: Resolution field selects microstep address bits.
// R17: Load angle limited to 64..88/256.
// R18: Index latch reads last captured count.
// R19: Index status flag set, cleared on read.
// R20: Sample pins; compare with previous sample.
`timescale 1ns/10ps
module encoder_index_vector
	import enc_vec_pkg::*;
#(
	parameter int SYNC_STAGES = SYNC_DEPTH
)(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic enc_a_i,
	input wire logic enc_b_i,
	input wire logic enc_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [31:0] x_actual_i,
	input wire logic [31:0] x_compare_i,
	input wire logic [12:0] microstep_adr_i,
	output logic position_match_out_o,
	output logic [7:0] commutation_angle_o,
	output logic vector_active_o,
	output logic index_event_o
);
	// A single flop would pass metastability straight into the decoder.
	if (SYNC_STAGES < 2) begin : g_check
		$error("SYNC_STAGES must be at least 2.");
	end

	logic [2:0] sync_q [SYNC_STAGES];
	logic [2:0] next_sync [SYNC_STAGES];
	logic [1:0] ab_prev;
	logic [31:0] enc_const;
	logic [31:0] count_q;
	logic [15:0] frac_acc;
	logic [13:0] cfg_word;
	logic [11:0] vector_constant;
	logic [1:0] vector_resolution;
	logic [1:0] load_sel;
	logic index_status;
	logic [31:0] index_latch;
	logic [31:0] next_enc_const;
	logic [31:0] next_count;
	logic [15:0] next_frac;
	logic [13:0] next_cfg;
	logic [11:0] next_vconst;
	logic [1:0] next_vres;
	logic [1:0] next_load;
	logic next_status;
	logic [31:0] next_latch;
	logic [31:0] next_rdata;
	logic next_match;
	logic [1:0] next_ab_prev;
	index_cfg_t cfg;
	logic a_s;
	logic b_s;
	logic n_s;
	logic step;
	logic up;
	logic ev;
	logic act;
	logic arm;
	logic wr_count;
	logic wr_angle;
	logic rd_status;
	logic [16:0] fmod;
	logic [16:0] fsum;
	logic [16:0] fdiff;
	logic carry;
	logic borrow;
	logic [31:0] int_ext;
	logic [7:0] vector_angle_now;

	// True when a write strobe hits the given offset; strobe and address are
	// arguments so that continuous assignments re-evaluate when they change.
	function automatic logic wr_hit(input logic wr, input logic [7:0] ad, input logic [7:0] a);
		return wr && (ad == a);
	endfunction : wr_hit

	// Pins pass a chain of flops; only the last stage is used by logic.
	always_comb begin
		next_sync[0] = {enc_n_i, enc_b_i, enc_a_i}; // see R20
		for (int i = 1; i < SYNC_STAGES; i++) begin
			next_sync[i] = sync_q[i-1];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				sync_q[i] <= 3'h0;
			end
		end else if (ce_i) begin
			sync_q <= next_sync;
		end
	end

	assign a_s = sync_q[SYNC_STAGES-1][0];
	assign b_s = sync_q[SYNC_STAGES-1][1];
	assign n_s = sync_q[SYNC_STAGES-1][2];
	assign cfg = decode_cfg(cfg_word);

	// A double change of A and B is an illegal jump and is not counted.
	assign step = ce_i && (a_s ^ ab_prev[0] ^ b_s ^ ab_prev[1]); // see R20
	assign up = ab_prev[0] ^ b_s;
	assign next_ab_prev = {b_s, a_s};

	index_detect u_index (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.a_i(a_s),
		.b_i(b_s),
		.n_i(n_s),
		.cfg_i(cfg),
		.arm_i(arm),
		.event_o(ev),
		.action_o(act)
	);

	assign arm = ce_i && wr_hit(reg_wr_i, reg_addr_i, ADDR_INDEX_CFG)
		&& reg_wdata_i[BIT_CLR_ONCE];
	assign wr_count = wr_hit(reg_wr_i, reg_addr_i, ADDR_ENC_COUNT);
	assign wr_angle = ce_i && wr_hit(reg_wr_i, reg_addr_i, ADDR_VEC_ANGLE);
	assign rd_status = reg_rd_i && (reg_addr_i == ADDR_INDEX_STATUS);
	assign index_event_o = ev;

	// Fraction wraps at the binary or decimal modulus.
	assign fmod = cfg.sel_decimal ? FRAC_MOD_DEC : FRAC_MOD_BIN; // see R10
	assign fsum = {1'b0, frac_acc} + {1'b0, enc_const[15:0]};
	assign fdiff = {1'b0, frac_acc} - {1'b0, enc_const[15:0]};
	assign carry = (fsum >= fmod);
	assign borrow = fdiff[16];
	assign int_ext = {{16{enc_const[31]}}, enc_const[31:16]};

	// Count path: software write, then index clear, then scaled step.
	always_comb begin
		next_count = count_q;
		next_frac = frac_acc;
		next_latch = index_latch;
		if (step) begin
			if (up) begin
				next_frac = carry ? 16'(fsum - fmod) : fsum[15:0];
				next_count = count_q + int_ext + {31'h0, carry};
			end else begin
				next_frac = borrow ? 16'(fdiff + fmod) : fdiff[15:0];
				next_count = count_q - int_ext - {31'h0, borrow};
			end
		end
		if (act) begin
			next_latch = count_q; // see R8
			if (cfg.clr_count) begin
				next_count = 32'h0000_0000;
				next_frac = 16'h0000;
			end
		end
		if (wr_count) begin
			next_count = reg_wdata_i;
			next_frac = 16'h0000;
		end
	end

	// Configuration registers written by software.
	always_comb begin
		next_enc_const = wr_hit(reg_wr_i, reg_addr_i, ADDR_ENC_CONST)
			? reg_wdata_i : enc_const;
		next_cfg = wr_hit(reg_wr_i, reg_addr_i, ADDR_INDEX_CFG)
			? reg_wdata_i[13:0] : cfg_word;
		next_vconst = wr_hit(reg_wr_i, reg_addr_i, ADDR_VEC_CONST)
			? reg_wdata_i[11:0] : vector_constant;
		next_vres = wr_hit(reg_wr_i, reg_addr_i, ADDR_VEC_RES)
			? reg_wdata_i[1:0] : vector_resolution;
		next_load = wr_hit(reg_wr_i, reg_addr_i, ADDR_VEC_RES)
			? reg_wdata_i[BIT_LOAD_SEL+:2] : load_sel;
	end

	// A new event in the read cycle keeps the flag so it is not lost.
	assign next_status = ev || (index_status && !rd_status); // see R19

	// Read data stand only in the cycle after the strobe; others read zero.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_ENC_COUNT: next_rdata = count_q;
				ADDR_INDEX_STATUS: next_rdata = {31'h0, index_status}; // see R19
				ADDR_INDEX_LATCH: next_rdata = index_latch; // see R18
				ADDR_VEC_ANGLE: next_rdata = {24'h0, vector_angle_now}; // see R15
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Compare source follows the configuration.
	assign next_match = (cfg.cmp_sel_enc ? count_q : x_actual_i) == x_compare_i; // see R9

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ab_prev <= 2'h0;
			enc_const <= RST_ENC_CONST;
			count_q <= 32'h0000_0000;
			frac_acc <= 16'h0000;
			cfg_word <= RST_INDEX_CFG;
			vector_constant <= RST_VEC_CONST; // see R12
			vector_resolution <= 2'h0;
			load_sel <= 2'h0;
			index_status <= 1'b0;
			index_latch <= 32'h0000_0000;
			reg_rdata_o <= 32'h0000_0000;
			position_match_out_o <= 1'b0;
		end else if (ce_i) begin
			ab_prev <= next_ab_prev;
			enc_const <= next_enc_const;
			count_q <= next_count;
			frac_acc <= next_frac;
			cfg_word <= next_cfg;
			vector_constant <= next_vconst;
			vector_resolution <= next_vres;
			load_sel <= next_load;
			index_status <= next_status;
			index_latch <= next_latch;
			reg_rdata_o <= next_rdata;
			position_match_out_o <= next_match;
		end
	end

	vector_angle u_vector (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.step_i(step),
		.up_i(up),
		.const_i(vector_constant),
		.wr_i(wr_angle),
		.wr_data_i(reg_wdata_i[7:0]),
		.res_i(vector_resolution),
		.load_sel_i(load_sel),
		.microstep_adr_i(microstep_adr_i),
		.angle_o(vector_angle_now),
		.field_angle_o(commutation_angle_o),
		.active_o(vector_active_o)
	);

	property p_latch;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		act |=> index_latch == $past(count_q);
	endproperty
	a_latch: assert property (p_latch) else $error("Latch missed the count."); // see R8

	property p_clear;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		act && cfg.clr_count && !wr_count |=> count_q == 32'h0000_0000;
	endproperty
	a_clear: assert property (p_clear) else $error("Count not cleared on index."); // see R8

	property p_keep;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		act && !cfg.clr_count && !wr_count && !step |=> $stable(count_q);
	endproperty
	a_keep: assert property (p_keep) else $error("Count changed with clear off."); // see R8

	property p_match;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		ce_i && cfg.cmp_sel_enc ##1 ce_i |-> position_match_out_o == ($past(count_q) == $past(x_compare_i));
	endproperty
	a_match: assert property (p_match) else $error("Compare used wrong source."); // see R9

	property p_dec;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		step && up && cfg.sel_decimal && !act && !wr_count && fsum >= FRAC_MOD_DEC
		|=> count_q == $past(count_q) + $past(int_ext) + 32'h0000_0001;
	endproperty
	a_dec: assert property (p_dec) else $error("Decimal carry missing."); // see R10

	property p_status;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		ev ##1 reg_rd_i && reg_addr_i == ADDR_INDEX_STATUS && ce_i |=> reg_rdata_o[0];
	endproperty
	a_status: assert property (p_status) else $error("Event flag not seen."); // see R19

	property p_rdclr;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		ce_i && rd_status && !ev |=> !index_status;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("Flag not cleared by read."); // see R19

	property p_rdlatch;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		ce_i && reg_rd_i && reg_addr_i == ADDR_INDEX_LATCH |=> reg_rdata_o == $past(index_latch);
	endproperty
	a_rdlatch: assert property (p_rdlatch) else $error("Latch read wrong."); // see R18

endmodule : encoder_index_vector

// File: common/enc_vec_pkg.sv
// Purpose: Shared constants and types for the encoder index and vector commutation block.
// Assumes: One 125 MHz core clock and a plain strobe register port.
// Notes: Register offsets are word indices on the plain port.
package enc_vec_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_ENC_CONST = 8'h10;
	localparam logic [7:0] ADDR_ENC_COUNT = 8'h11;
	localparam logic [7:0] ADDR_INDEX_CFG = 8'h12;
	localparam logic [7:0] ADDR_INDEX_STATUS = 8'h13;
	localparam logic [7:0] ADDR_INDEX_LATCH = 8'h14;
	localparam logic [7:0] ADDR_VEC_CONST = 8'h17;
	localparam logic [7:0] ADDR_VEC_ANGLE = 8'h18;
	localparam logic [7:0] ADDR_VEC_RES = 8'h19;

	// Field positions of the index configuration word; BIT_LOAD_SEL is in the vector resolution word.
	localparam int BIT_POL_A = 0;
	localparam int BIT_POL_B = 1;
	localparam int BIT_POL_N = 2;
	localparam int BIT_SKIP_QUAD = 3;
	localparam int BIT_CLR_CONT = 4;
	localparam int BIT_CLR_ONCE = 5;
	localparam int BIT_POS_EDGE = 6;
	localparam int BIT_NEG_EDGE = 7;
	localparam int BIT_CLR_COUNT = 8;
	localparam int BIT_CMP_SEL = 12;
	localparam int BIT_SEL_DEC = 13;
	localparam int BIT_LOAD_SEL = 8;

	// Reset values; the accumulation constant starts at 1.0.
	localparam logic [31:0] RST_ENC_CONST = 32'h0001_0000;
	localparam logic [13:0] RST_INDEX_CFG = 14'h0000;
	localparam logic [11:0] RST_VEC_CONST = 12'h000;
	localparam logic [7:0] RST_VEC_ANGLE = 8'h00;

	// Fraction moduli for binary and decimal scaling.
	localparam logic [16:0] FRAC_MOD_BIN = 17'h10000;
	localparam logic [16:0] FRAC_MOD_DEC = 17'h02710;

	// Load angle limits in 1/256 electrical period.
	localparam logic [7:0] LOAD_LIM_0 = 8'h40;
	localparam logic [7:0] LOAD_LIM_1 = 8'h48;
	localparam logic [7:0] LOAD_LIM_2 = 8'h50;
	localparam logic [7:0] LOAD_LIM_3 = 8'h58;

	// Synchroniser depth for pins.
	localparam int SYNC_DEPTH = 2;

	typedef struct packed {
		logic pol_a;
		logic pol_b;
		logic pol_n;
		logic skip_quadrature_qualify;
		logic clr_cont;
		logic clr_once;
		logic pos_edge;
		logic neg_edge;
		logic clr_count;
		logic cmp_sel_enc;
		logic sel_decimal;
	} index_cfg_t;

	// Unpack the stored configuration word into named fields.
	function automatic index_cfg_t decode_cfg(input logic [13:0] w);
		index_cfg_t c;
		c.pol_a = w[BIT_POL_A];
		c.pol_b = w[BIT_POL_B];
		c.pol_n = w[BIT_POL_N];
		c.skip_quadrature_qualify = w[BIT_SKIP_QUAD];
		c.clr_cont = w[BIT_CLR_CONT];
		c.clr_once = w[BIT_CLR_ONCE];
		c.pos_edge = w[BIT_POS_EDGE];
		c.neg_edge = w[BIT_NEG_EDGE];
		c.clr_count = w[BIT_CLR_COUNT];
		c.cmp_sel_enc = w[BIT_CMP_SEL];
		c.sel_decimal = w[BIT_SEL_DEC];
		return c;
	endfunction : decode_cfg

endpackage : enc_vec_pkg

// File: logic/index_detect.sv
// Purpose: Index event detection, qualification and single-shot arming.
// Assumes: Inputs are already synchronised to core_clk_i.
// Notes: Event and action are combinational strobes gated by ce_i.
`timescale 1ns/10ps
module index_detect
	import enc_vec_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic a_i,
	input wire logic b_i,
	input wire logic n_i,
	input wire index_cfg_t cfg_i,
	input wire logic arm_i,
	output logic event_o,
	output logic action_o
);
	logic n_prev;
	logic armed;
	logic next_n_prev;
	logic next_armed;
	logic n_act;
	logic prev_act;
	logic trig;
	logic qual;

	// Index is active when it equals the configured level.
	assign n_act = n_i ~^ cfg_i.pol_n; // see R2
	assign prev_act = n_prev ~^ cfg_i.pol_n; // see R20

	// Edge modes replace level mode; both edge bits give either edge.
	always_comb begin
		trig = n_act;
		if (cfg_i.pos_edge || cfg_i.neg_edge) begin
			trig = (cfg_i.pos_edge && n_act && !prev_act) // see R6
				|| (cfg_i.neg_edge && !n_act && prev_act); // see R7
		end
	end

	// Quadrature qualification can be bypassed.
	assign qual = cfg_i.skip_quadrature_qualify // see R3
		|| ((a_i == cfg_i.pol_a) && (b_i == cfg_i.pol_b)); // see R1
	assign event_o = ce_i && trig && qual;
	assign action_o = event_o && (cfg_i.clr_cont || armed); // see R4

	// Arming on a configuration write beats the disarm of a same-cycle event.
	always_comb begin
		next_n_prev = n_i;
		next_armed = armed;
		if (event_o && armed) begin
			next_armed = 1'b0; // see R5
		end
		if (arm_i) begin
			next_armed = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			n_prev <= 1'b0;
			armed <= 1'b0;
		end else if (ce_i) begin
			n_prev <= next_n_prev;
			armed <= next_armed;
		end
	end

	property p_qual;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		event_o && !cfg_i.skip_quadrature_qualify |-> a_i == cfg_i.pol_a && b_i == cfg_i.pol_b;
	endproperty
	a_qual: assert property (p_qual) else $error("Index accepted with wrong A/B."); // see R1

	property p_once;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		event_o && armed && !arm_i |=> !armed;
	endproperty
	a_once: assert property (p_once) else $error("Single shot stayed armed."); // see R5

	property p_cont;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		event_o && cfg_i.clr_cont |-> action_o;
	endproperty
	a_cont: assert property (p_cont) else $error("Continuous action missed."); // see R4

	property p_rise;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		event_o && cfg_i.pos_edge && !cfg_i.neg_edge |-> n_act && !prev_act;
	endproperty
	a_rise: assert property (p_rise) else $error("Rising event without rise."); // see R6

	property p_fall;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		event_o && cfg_i.neg_edge && !cfg_i.pos_edge |-> !n_act && prev_act;
	endproperty
	a_fall: assert property (p_fall) else $error("Falling event without fall."); // see R7

endmodule : index_detect

// File: logic/vector_angle.sv
// Purpose: Encoder angle accumulation and load-angle limited commutation angle.
// Assumes: step_i is a one-cycle count strobe with direction up_i.
// Notes: A zero constant freezes the angle and drops vector_active_o.
`timescale 1ns/10ps
module vector_angle
	import enc_vec_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic step_i,
	input wire logic up_i,
	input wire logic [11:0] const_i,
	input wire logic wr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [1:0] res_i,
	input wire logic [1:0] load_sel_i,
	input wire logic [12:0] microstep_adr_i,
	output logic [7:0] angle_o,
	output logic [7:0] field_angle_o,
	output logic active_o
);
	logic [13:0] acc;
	logic [13:0] next_acc;
	logic [7:0] next_field;
	logic [7:0] motor;
	logic [7:0] lim;
	logic signed [7:0] diff;
	logic signed [7:0] clipped;

	// Pick the eight microstep address bits that span one period.
	function automatic logic [7:0] pick(input logic [12:0] adr, input logic [1:0] r);
		case (r)
			2'h0: pick = adr[12:5]; // see R16
			2'h1: pick = adr[11:4];
			2'h2: pick = adr[9:2];
			default: pick = adr[7:0];
		endcase
	endfunction : pick

	// Map the load selection code to its angle limit.
	function automatic logic [7:0] limit(input logic [1:0] s);
		case (s)
			2'h0: limit = LOAD_LIM_0; // see R17
			2'h1: limit = LOAD_LIM_1;
			2'h2: limit = LOAD_LIM_2;
			default: limit = LOAD_LIM_3;
		endcase
	endfunction : limit

	assign angle_o = acc[13:6];
	assign active_o = (const_i != 12'h000); // see R12
	assign motor = pick(microstep_adr_i, res_i);
	assign lim = limit(load_sel_i);
	assign diff = $signed(motor - angle_o);

	// Clip the lead of the microstep angle over the rotor angle.
	always_comb begin
		clipped = diff;
		if (diff > $signed(lim)) begin
			clipped = $signed(lim);
		end else if (diff < -$signed(lim)) begin
			clipped = -$signed(lim);
		end
	end

	// Software writes win over a same-cycle count so initialisation is exact.
	always_comb begin
		next_acc = acc;
		next_field = angle_o + 8'(clipped);
		if (wr_i) begin
			next_acc = {wr_data_i, 6'h00}; // see R15
		end else if (step_i && active_o) begin
			if (up_i) begin
				next_acc = acc + {{2{const_i[11]}}, const_i}; // see R11
			end else begin
				next_acc = acc - {{2{const_i[11]}}, const_i};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			acc <= {RST_VEC_ANGLE, 6'h00};
			field_angle_o <= 8'h00;
		end else if (ce_i) begin
			acc <= next_acc;
			field_angle_o <= next_field;
		end
	end

	property p_off;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		!active_o && !wr_i |=> $stable(acc);
	endproperty
	a_off: assert property (p_off) else $error("Angle moved with vector control off."); // see R12

	property p_lim;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		ce_i |=> $signed(8'(field_angle_o - $past(angle_o))) <= $signed($past(lim))
			&& $signed(8'(field_angle_o - $past(angle_o))) >= -$signed($past(lim));
	endproperty
	a_lim: assert property (p_lim) else $error("Load angle exceeds limit."); // see R17

endmodule : vector_angle

// File: dv/quad_encoder_model.sv
// Purpose: Behavioural quadrature encoder with an index channel.
// Assumes: Pins change only just after rising clock edges.
// Notes: Each A/B state is held four cycles so the pin synchroniser never drops a count.
`timescale 1ns/10ps
module quad_encoder_model (
	input wire logic clk_i,
	output logic a_o,
	output logic b_o,
	output logic n_o
);
	int phase = 0;

	// Pins start idle at a known level.
	initial begin
		a_o = 1'b0;
		b_o = 1'b0;
		n_o = 1'b0;
	end

	// One count in gray order, so A and B never change together.
	task automatic step(input bit up);
		phase = up ? (phase + 1) % 4 : (phase + 3) % 4;
		@(posedge clk_i);
		a_o <= phase[1];
		b_o <= phase[1] ^ phase[0];
		repeat (3) @(posedge clk_i);
	endtask : step

	// Drives the index pin and holds it for a number of sampling edges.
	task automatic index_level(input bit lvl, input int hold);
		n_o <= lvl;
		repeat (hold) @(posedge clk_i);
	endtask : index_level
endmodule : quad_encoder_model

// File: dv/encoder_index_vector_bench.sv
// Purpose: Self-checking bench for the encoder index and vector commutation block.
// Assumes: Bus strobes move right after rising edges; the encoder model drives the pins.
// Notes: Integer models track count, latch and angle; waits cover the pin synchroniser.
`timescale 1ns/10ps
module encoder_index_vector_bench;
	import enc_vec_pkg::*;
	localparam int PA = 1 << BIT_POL_A, PB = 1 << BIT_POL_B, PN = 1 << BIT_POL_N;
	localparam int SQ = 1 << BIT_SKIP_QUAD, CC = 1 << BIT_CLR_CONT, C1 = 1 << BIT_CLR_ONCE;
	localparam int PE = 1 << BIT_POS_EDGE, NE = 1 << BIT_NEG_EDGE, CL = 1 << BIT_CLR_COUNT;
	localparam int CS = 1 << BIT_CMP_SEL, SD = 1 << BIT_SEL_DEC;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, xa = 32'h0, xc = 32'h1, rdata, v;
	logic [12:0] madr = 13'h0;
	logic a, b, n, match, active, evt;
	logic [7:0] cang, ang;
	logic [13:0] vacc = 14'h0;
	logic [11:0] vc = 12'h0;
	logic [11:0] vtab [3] = '{12'h040, 12'hfa0, 12'h020};
	int n_mismatch = 0, checks = 0, nev = 0, e0 = 0;
	int cnt = 0, frac = 0, latch = 0, cint = 1, cfr = 0, fmod = 65536;

	encoder_index_vector encoder_index_vector_inst (.core_clk_i(clk), .rst_b_i(rst_b),
		.ce_i(1'b1), .enc_a_i(a), .enc_b_i(b), .enc_n_i(n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.x_actual_i(xa), .x_compare_i(xc), .microstep_adr_i(madr),
		.position_match_out_o(match), .commutation_angle_o(cang),
		.vector_active_o(active), .index_event_o(evt));
	quad_encoder_model quad_encoder_model_inst (.clk_i(clk), .a_o(a), .b_o(b), .n_o(n));

	// 125 MHz core clock.
	initial begin
		forever #4 clk = ~clk;
	end

	// Counts cycles with the index event strobe high.
	always @(posedge clk) begin
		if (evt === 1'b1) nev <= nev + 1;
	end

	// A hang ends the run well after the sequence should be done.
	initial begin
		#400000;
		n_mismatch++;
		wrap_up();
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", ad), rdata, exp);
	endtask : rchk

	// One encoder count, mirrored in the count and angle models.
	task automatic step(input bit up);
		logic [13:0] c;
		c = {{2{vc[11]}}, vc};
		quad_encoder_model_inst.step(up);
		if (up) begin
			frac += cfr;
			cnt += cint + int'(frac >= fmod);
			frac %= fmod;
			vacc += c;
		end else begin
			frac -= cfr;
			cnt -= cint + int'(frac < 0);
			if (frac < 0) frac += fmod;
			vacc -= c;
		end
		repeat (4) @(posedge clk);
	endtask : step

	task automatic pulse(input bit act);
		quad_encoder_model_inst.index_level(act, 4);
		quad_encoder_model_inst.index_level(!act, 6);
	endtask : pulse

	// Angle pulled toward the microstep angle, limited to the load window.
	function automatic logic [7:0] comm(logic [12:0] m, logic [1:0] r, logic [1:0] l,
		logic [7:0] g);
		logic [7:0] s;
		int d;
		int lim;
		s = (r == 2'd0) ? m[12:5] : (r == 2'd1) ? m[11:4] : (r == 2'd2) ? m[9:2] : m[7:0];
		s = s - g;
		d = $signed(s);
		lim = 64 + 8 * int'(l);
		if (d > lim) d = lim;
		if (d < -lim) d = -lim;
		return 8'(int'(g) + d);
	endfunction : comm

	initial begin
		void'($urandom(32'h00f9a180));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rchk(ADDR_ENC_COUNT, 0);
		// The idle low index is active at the reset polarity with A and B low.
		rchk(ADDR_INDEX_STATUS, 1);
		rchk(ADDR_INDEX_LATCH, 0);
		rchk(ADDR_INDEX_CFG, 0);
		rchk(8'h7f, 0);
		chk("vector active", active, 0);
		repeat (6) step(1);
		step(0);
		step(1);
		rchk(ADDR_ENC_COUNT, cnt);
		// A and B now both high; qualified rising index.
		wreg(ADDR_INDEX_CFG, PA | PB | PN | CC | PE);
		e0 = nev;
		pulse(1);
		latch = cnt;
		chk("event pulses", nev - e0, 1);
		rchk(ADDR_INDEX_LATCH, latch);
		rchk(ADDR_INDEX_STATUS, 1);
		rchk(ADDR_INDEX_STATUS, 0);
		rchk(ADDR_ENC_COUNT, cnt);
		wreg(ADDR_INDEX_CFG, PA | PN | CC | PE);
		pulse(1);
		rchk(ADDR_INDEX_STATUS, 0);
		wreg(ADDR_INDEX_CFG, PA | PN | SQ | CC | PE);
		pulse(1);
		rchk(ADDR_INDEX_STATUS, 1);
		// Active-low index, single shot with clear.
		quad_encoder_model_inst.index_level(1, 6);
		wreg(ADDR_INDEX_CFG, SQ | C1 | CL | PE);
		rchk(ADDR_INDEX_STATUS, 1);
		pulse(0);
		latch = cnt;
		cnt = 0;
		rchk(ADDR_ENC_COUNT, cnt);
		rchk(ADDR_INDEX_LATCH, latch);
		repeat (3) step(1);
		pulse(0);
		rchk(ADDR_ENC_COUNT, cnt);
		rchk(ADDR_INDEX_STATUS, 1);
		rchk(ADDR_INDEX_LATCH, latch);
		quad_encoder_model_inst.index_level(0, 6);
		wreg(ADDR_INDEX_CFG, PN | SQ | CC | NE);
		rchk(ADDR_INDEX_STATUS, 1);
		e0 = nev;
		quad_encoder_model_inst.index_level(1, 6);
		chk("event pulses", nev - e0, 0);
		quad_encoder_model_inst.index_level(0, 6);
		chk("event pulses", nev - e0, 1);
		latch = cnt;
		rchk(ADDR_INDEX_LATCH, latch);
		// Level mode acts on every active cycle.
		wreg(ADDR_INDEX_CFG, PN | SQ | CC | CL);
		e0 = nev;
		quad_encoder_model_inst.index_level(1, 5);
		quad_encoder_model_inst.index_level(0, 6);
		chk("event pulses", nev - e0, 5);
		cnt = 0;
		rchk(ADDR_ENC_COUNT, 0);
		rchk(ADDR_INDEX_LATCH, 0);
		// Same constant in binary and decimal fraction units.
		for (int m = 0; m < 2; m++) begin
			wreg(ADDR_INDEX_CFG, (m == 1) ? SD : 0);
			fmod = (m == 1) ? 10000 : 65536;
			wreg(ADDR_ENC_CONST, 32'h0000_1388);
			cint = 0;
			cfr = 5000;
			wreg(ADDR_ENC_COUNT, 0);
			cnt = 0;
			frac = 0;
			repeat (3) step(1);
			rchk(ADDR_ENC_COUNT, cnt);
		end
		// Compare source: ramp position, then encoder count.
		@(posedge clk);
		v = $urandom;
		xa <= v;
		xc <= v;
		repeat (3) @(posedge clk);
		#1;
		chk("match ramp", match, 1);
		@(posedge clk);
		xc <= v + 32'h1;
		repeat (3) @(posedge clk);
		#1;
		chk("match ramp", match, 0);
		wreg(ADDR_INDEX_CFG, CS);
		xc <= cnt;
		repeat (3) @(posedge clk);
		#1;
		chk("match count", match, 1);
		// Vector angle accumulation for several signed constants.
		wreg(ADDR_VEC_CONST, 32'h040);
		vc = 12'h040;
		rchk(ADDR_VEC_CONST, 0);
		chk("vector active", active, 1);
		ang = 8'($urandom);
		wreg(ADDR_VEC_ANGLE, {24'h0, ang});
		vacc = {ang, 6'h0};
		rchk(ADDR_VEC_ANGLE, ang);
		for (int k = 0; k < 3; k++) begin
			wreg(ADDR_VEC_CONST, {20'h0, vtab[k]});
			vc = vtab[k];
			repeat (2) step(1);
			step(0);
			rchk(ADDR_VEC_ANGLE, vacc[13:6]);
		end
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			madr <= 13'($urandom);
			wreg(ADDR_VEC_RES, {22'h0, k[3:2], 6'h0, k[1:0]});
			repeat (3) @(posedge clk);
			#1;
			chk("commutation", cang, comm(madr, k[1:0], k[3:2], vacc[13:6]));
		end
		wreg(ADDR_VEC_CONST, 0);
		vc = 12'h000;
		#1;
		chk("vector active", active, 0);
		step(1);
		rchk(ADDR_VEC_ANGLE, vacc[13:6]);
		wrap_up();
	end
endmodule : encoder_index_vector_bench
